// file: design/fspr_pkg.sv
// Functional notes
// - Resume is opcode D0h; extra bytes ignored.
// - Resume at select rise, clear suspend flag.
// - Report busy while resumed operation runs.
// - Program resumes before erase; resume again.
// - Suspend ignored while resume still settling.
// - Host waits resume time before suspending.
// - Reset clears software protection enable.
// - 3D 2A 7F A9 then select rise enables.
// - 3D 2A 7F 9A then select rise disables.
// - Enabled protection blocks marked sectors.
// - Asserted pin blocks marked sectors, table.
// - Pin asserts protection; release drops it unless software enabled.
// - Software enable survives pin release.
// - Disable ignored while pin asserted.
// - Pin protects sectors and table; status shows state.
// - Pin input filtered against glitches.
// - Table byte FFh marks sector protected.
// - Suspend flags set while suspended, both possible.
package fspr_pkg;

  // ==========================================================================
  // Link opcodes
  localparam logic [7:0] OP_RESUME    = 8'hd0;
  localparam logic [7:0] OP_STATUS    = 8'hd7;
  localparam logic [7:0] SEQ_B0       = 8'h3d;
  localparam logic [7:0] SEQ_B1       = 8'h2a;
  localparam logic [7:0] SEQ_B2       = 8'h7f;
  localparam logic [7:0] SEQ_ENABLE   = 8'ha9;
  localparam logic [7:0] SEQ_DISABLE  = 8'h9a;
  localparam logic [7:0] TBL_PROTECT  = 8'hff;
  localparam int         SEQ_BYTES    = 4;

  // ==========================================================================
  // Status byte bit positions
  localparam int ST_RDY   = 7;
  localparam int ST_ES    = 6;
  localparam int ST_PSA   = 5;
  localparam int ST_PSB   = 4;
  localparam int ST_PROT  = 1;
  localparam int ST_RSM   = 0;

  // ==========================================================================
  // Suspend kinds from the array engine
  localparam logic [1:0] SUSP_PROG_A = 2'h0;
  localparam logic [1:0] SUSP_PROG_B = 2'h1;
  localparam logic [1:0] SUSP_ERASE  = 2'h2;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ          = 250;
  localparam int RESUME_TIME_NS   = 20000;
  localparam int WP_FILTER_NS     = 40;
  localparam int RESUME_CYC_DEF   = (RESUME_TIME_NS * CLK_MHZ) / 1000;
  localparam int WP_FILT_CYC_DEF  = (WP_FILTER_NS * CLK_MHZ) / 1000;
  localparam int SCK_HALF_DEF     = 8;
  localparam int GAP_TICKS        = 2;

  // ==========================================================================
  // Host register map and fields
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_WPCTL    = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h10;
  localparam logic [7:0] REG_IRQ_EN   = 8'h14;
  localparam logic [1:0] CMD_RESUME   = 2'h0;
  localparam logic [1:0] CMD_ENABLE   = 2'h1;
  localparam logic [1:0] CMD_DISABLE  = 2'h2;
  localparam logic [1:0] CMD_STATUS   = 2'h3;
  localparam int         IRQ_W        = 2;
  localparam int         IRQ_DONE     = 0;
  localparam int         IRQ_GUARD    = 1;
  localparam int         STR_BUSY     = 0;
  localparam int         STR_GUARD    = 1;
  localparam int         STR_BYTE_LSB = 8;

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} fspr_host_st_t;

endpackage

// file: design/fspr_link_if.sv
`timescale 1ns/1ps
interface fspr_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic wp_n;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // Undriven data line floats high through the pull-up
  assign miso = miso_oe ? miso_o : 1'b1;

  modport device (input sck, input cs_n, input mosi, input wp_n, output miso_o, output miso_oe);
  modport host   (output sck, output cs_n, output mosi, output wp_n, input miso);
endinterface

// file: design/fspr_pin_filter.sv
`timescale 1ns/1ps
module fspr_pin_filter #(
  parameter int   STABLE_CYC = 1,
  parameter logic RST_VAL    = 1'b1
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Pin
  input  wire logic pin_in,
  output logic      pin_out
);

  localparam int CW = (STABLE_CYC > 1) ? $clog2(STABLE_CYC) : 1;

  logic          s1_ff;
  logic          s2_ff;
  logic          s3_ff;
  logic [CW-1:0] cnt_ff;

  // ==========================================================================
  // Synchroniser
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end
    else
    begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // ==========================================================================
  // Stability filter: any disagreement restarts the count
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cnt_ff  <= '0;
      pin_out <= RST_VAL;
    end
    else if (s2_ff != s3_ff || s3_ff == pin_out)
      cnt_ff <= '0;
    else if (cnt_ff == CW'(STABLE_CYC - 1))
    begin
      cnt_ff  <= '0;
      pin_out <= s3_ff;
    end
    else
      cnt_ff <= cnt_ff + 1'b1;
  end

endmodule // fspr_pin_filter

// file: design/fspr_device.sv
`timescale 1ns/1ps
module fspr_device
  import fspr_pkg::*;
#(
  parameter int RESUME_CYC  = RESUME_CYC_DEF,
  parameter int WP_FILT_CYC = WP_FILT_CYC_DEF
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Serial link
  fspr_link_if.device     link,
  // Array engine
  input  wire logic       op_start,
  input  wire logic       op_done,
  input  wire logic       susp_req,
  input  wire logic [1:0] susp_kind,
  output logic            resume_prog,
  output logic            resume_erase,
  output logic            busy,
  output logic            resuming,
  // Suspend and protection state
  output logic            prog_suspend_flag_a,
  output logic            prog_suspend_flag_b,
  output logic            erase_suspend_flag,
  output logic            prot_en,
  // Access check
  input  wire logic       chk_valid,
  input  wire logic       chk_table,
  input  wire logic [7:0] chk_tbl_byte,
  output logic            chk_done,
  output logic            chk_deny
);

  localparam int RW = $clog2(RESUME_CYC + 1);

  logic          sck_f;
  logic          cs_n_f;
  logic          mosi_f;
  logic          wp_n_f;
  logic          sck_d_ff;
  logic          cs_n_d_ff;
  logic          sck_rise;
  logic          sck_fall;
  logic          cs_rise;
  logic          cs_fall;
  logic [7:0]    sr_ff;
  logic [7:0]    nxt_byte;
  logic [2:0]    bit_cnt_ff;
  logic [2:0]    byte_cnt_ff;
  logic          is_resume_ff;
  logic          is_status_ff;
  logic          seq_ok_ff;
  logic [7:0]    last_byte_ff;
  logic [7:0]    stat_sr_ff;
  logic [7:0]    status_byte;
  logic          seq_full;
  logic          resume_go;
  logic          susp_ok;
  logic          wp_act;
  logic          sw_en_ff;
  logic [RW-1:0] rsm_cnt_ff;

  // ==========================================================================
  // Pin conditioning
  fspr_pin_filter #(.STABLE_CYC(1), .RST_VAL(1'b0)) u_sck (
    .clk_sys (clk_sys), .sys_rst (sys_rst), .pin_in (link.sck), .pin_out (sck_f));
  fspr_pin_filter #(.STABLE_CYC(1), .RST_VAL(1'b1)) u_cs (
    .clk_sys (clk_sys), .sys_rst (sys_rst), .pin_in (link.cs_n), .pin_out (cs_n_f));
  fspr_pin_filter #(.STABLE_CYC(1), .RST_VAL(1'b0)) u_mosi (
    .clk_sys (clk_sys), .sys_rst (sys_rst), .pin_in (link.mosi), .pin_out (mosi_f));
  // Long filter rejects glitches on the protect pin
  fspr_pin_filter #(.STABLE_CYC(WP_FILT_CYC), .RST_VAL(1'b1)) u_wp (
    .clk_sys (clk_sys), .sys_rst (sys_rst), .pin_in (link.wp_n), .pin_out (wp_n_f));

  assign wp_act = ~wp_n_f;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sck_d_ff  <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end
    else
    begin
      sck_d_ff  <= sck_f;
      cs_n_d_ff <= cs_n_f;
    end
  end

  assign sck_rise = sck_f & ~sck_d_ff & ~cs_n_f;
  assign sck_fall = ~sck_f & sck_d_ff & ~cs_n_d_ff;
  assign cs_rise  = cs_n_f & ~cs_n_d_ff;
  assign cs_fall  = ~cs_n_f & cs_n_d_ff;
  assign nxt_byte = {sr_ff[6:0], mosi_f};

  // ==========================================================================
  // Command receiver
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || cs_fall)
    begin
      sr_ff        <= '0;
      bit_cnt_ff   <= '0;
      byte_cnt_ff  <= '0;
      is_resume_ff <= 1'b0;
      is_status_ff <= 1'b0;
      seq_ok_ff    <= 1'b0;
      last_byte_ff <= '0;
    end
    else if (sck_rise)
    begin
      sr_ff      <= nxt_byte;
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
      if (bit_cnt_ff == 3'h7)
      begin
        last_byte_ff <= nxt_byte;
        // Count saturates past the sequence length so overruns never match
        if (byte_cnt_ff <= 3'(SEQ_BYTES))
          byte_cnt_ff <= byte_cnt_ff + 1'b1;
        unique case (byte_cnt_ff)
          3'h0:
          begin
            is_resume_ff <= (nxt_byte == OP_RESUME);
            is_status_ff <= (nxt_byte == OP_STATUS);
            seq_ok_ff    <= (nxt_byte == SEQ_B0);
          end
          3'h1:    seq_ok_ff <= seq_ok_ff & (nxt_byte == SEQ_B1);
          3'h2:    seq_ok_ff <= seq_ok_ff & (nxt_byte == SEQ_B2);
          default: ;
        endcase
      end
    end
  end

  // Exactly four whole bytes, nothing partial after them
  assign seq_full = seq_ok_ff && byte_cnt_ff == 3'(SEQ_BYTES) && bit_cnt_ff == 3'h0;

  // ==========================================================================
  // Status read-out
  always_comb
  begin
    status_byte          = '0;
    status_byte[ST_RDY]  = ~busy;
    status_byte[ST_ES]   = erase_suspend_flag;
    status_byte[ST_PSA]  = prog_suspend_flag_a;
    status_byte[ST_PSB]  = prog_suspend_flag_b;
    status_byte[ST_PROT] = prot_en;
    status_byte[ST_RSM]  = resuming;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      stat_sr_ff   <= '0;
      link.miso_o  <= 1'b1;
      link.miso_oe <= 1'b0;
    end
    else
    begin
      link.miso_oe <= ~cs_n_f;
      if (sck_rise && bit_cnt_ff == 3'h7 && byte_cnt_ff == 3'h0)
        stat_sr_ff <= status_byte;
      else if (sck_fall && is_status_ff)
      begin
        link.miso_o <= stat_sr_ff[7];
        stat_sr_ff  <= {stat_sr_ff[6:0], stat_sr_ff[7]};
      end
    end
  end

  // ==========================================================================
  // Resume and suspend
  assign resume_go = cs_rise & is_resume_ff & ~busy
                   & (prog_suspend_flag_a | prog_suspend_flag_b | erase_suspend_flag);
  // Suspend only lands on a running operation that has finished resuming
  assign susp_ok   = susp_req & busy & ~resuming;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      prog_suspend_flag_a <= 1'b0;
      prog_suspend_flag_b <= 1'b0;
      erase_suspend_flag  <= 1'b0;
    end
    else if (resume_go)
    begin
      if (prog_suspend_flag_a)
        prog_suspend_flag_a <= 1'b0;
      else if (prog_suspend_flag_b)
        prog_suspend_flag_b <= 1'b0;
      else
        erase_suspend_flag <= 1'b0;
    end
    else if (susp_ok)
    begin
      unique case (susp_kind)
        SUSP_PROG_A: prog_suspend_flag_a <= 1'b1;
        SUSP_PROG_B: prog_suspend_flag_b <= 1'b1;
        SUSP_ERASE:  erase_suspend_flag  <= 1'b1;
        default:     ;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      busy <= 1'b0;
    else if (resume_go || op_start)
      busy <= 1'b1;
    else if (op_done || susp_ok)
      busy <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      resuming   <= 1'b0;
      rsm_cnt_ff <= '0;
    end
    else if (resume_go)
    begin
      resuming   <= 1'b1;
      rsm_cnt_ff <= RW'(RESUME_CYC - 1);
    end
    else if (resuming)
    begin
      if (rsm_cnt_ff == '0)
        resuming <= 1'b0;
      else
        rsm_cnt_ff <= rsm_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      resume_prog  <= 1'b0;
      resume_erase <= 1'b0;
    end
    else
    begin
      resume_prog  <= resume_go & (prog_suspend_flag_a | prog_suspend_flag_b);
      resume_erase <= resume_go & ~(prog_suspend_flag_a | prog_suspend_flag_b);
    end
  end

  // ==========================================================================
  // Sector protection
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      sw_en_ff <= 1'b0;
    else if (cs_rise && seq_full && last_byte_ff == SEQ_ENABLE)
      sw_en_ff <= 1'b1;
    else if (cs_rise && seq_full && last_byte_ff == SEQ_DISABLE && !wp_act)
      sw_en_ff <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      prot_en <= 1'b0;
    else
      prot_en <= sw_en_ff | wp_act;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      chk_done <= 1'b0;
      chk_deny <= 1'b0;
    end
    else
    begin
      chk_done <= chk_valid;
      // Table itself is guarded by the pin alone
      if (chk_table)
        chk_deny <= chk_valid & wp_act;
      else
        chk_deny <= chk_valid & prot_en & (chk_tbl_byte == TBL_PROTECT);
    end
  end

endmodule // fspr_device

// file: design/fspr_host.sv
`timescale 1ns/1ps
module fspr_host
  import fspr_pkg::*;
#(
  parameter int SCK_HALF   = SCK_HALF_DEF,
  parameter int RESUME_CYC = RESUME_CYC_DEF
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Serial link
  fspr_link_if.host        link,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Interrupt
  output logic             irq
);

  localparam int DW = $clog2(SCK_HALF + 1);
  localparam int RW = $clog2(RESUME_CYC + 1);

  fspr_host_st_t    st_ff;
  logic [DW-1:0]    div_ff;
  logic             tick;
  logic [31:0]      tx_sr_ff;
  logic [5:0]       bits_ff;
  logic [7:0]       rx_sr_ff;
  logic [7:0]       stat_byte_ff;
  logic [1:0]       cmd_ff;
  logic [1:0]       gap_ff;
  logic             start;
  logic             done;
  logic [RW-1:0]    guard_ff;
  logic             guard_end;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic [IRQ_W-1:0] irq_set;

  assign start = reg_wr && reg_addr == REG_CTRL && st_ff == H_IDLE;
  assign tick  = div_ff == DW'(SCK_HALF - 1);
  assign done  = st_ff == H_GAP && tick && gap_ff == 2'(GAP_TICKS - 1);

  // ==========================================================================
  // Clock divider
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || st_ff == H_IDLE || tick)
      div_ff <= '0;
    else
      div_ff <= div_ff + 1'b1;
  end

  // ==========================================================================
  // Frame engine, mode 0, most significant bit first
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_ff     <= H_IDLE;
      link.sck  <= 1'b0;
      link.cs_n <= 1'b1;
      tx_sr_ff  <= '0;
      bits_ff   <= '0;
      rx_sr_ff  <= '0;
      cmd_ff    <= CMD_RESUME;
      gap_ff    <= '0;
    end
    else
    begin
      unique case (st_ff)
        H_IDLE:
          if (start)
          begin
            cmd_ff    <= reg_wdata[1:0];
            link.cs_n <= 1'b0;
            st_ff     <= H_SHIFT;
            unique case (reg_wdata[1:0])
              CMD_RESUME:
              begin
                tx_sr_ff <= {OP_RESUME, 24'h000000};
                bits_ff  <= 6'h08;
              end
              CMD_ENABLE:
              begin
                tx_sr_ff <= {SEQ_B0, SEQ_B1, SEQ_B2, SEQ_ENABLE};
                bits_ff  <= 6'h20;
              end
              CMD_DISABLE:
              begin
                tx_sr_ff <= {SEQ_B0, SEQ_B1, SEQ_B2, SEQ_DISABLE};
                bits_ff  <= 6'h20;
              end
              CMD_STATUS:
              begin
                tx_sr_ff <= {OP_STATUS, 24'h000000};
                bits_ff  <= 6'h10;
              end
            endcase
          end
        H_SHIFT:
          if (tick)
          begin
            link.sck <= ~link.sck;
            if (!link.sck)
              rx_sr_ff <= {rx_sr_ff[6:0], link.miso};
            else
            begin
              tx_sr_ff <= {tx_sr_ff[30:0], 1'b0};
              bits_ff  <= bits_ff - 1'b1;
              // Select rises only after the last whole byte
              if (bits_ff == 6'h01)
              begin
                link.cs_n <= 1'b1;
                gap_ff    <= '0;
                st_ff     <= H_GAP;
              end
            end
          end
        H_GAP:
          if (tick)
          begin
            gap_ff <= gap_ff + 1'b1;
            if (done)
              st_ff <= H_IDLE;
          end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  assign link.mosi = tx_sr_ff[31];

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      stat_byte_ff <= '0;
    else if (done && cmd_ff == CMD_STATUS)
      stat_byte_ff <= rx_sr_ff;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      link.wp_n <= 1'b1;
    else if (reg_wr && reg_addr == REG_WPCTL)
      link.wp_n <= ~reg_wdata[0];
  end

  // ==========================================================================
  // Suspend guard: counts the full resume time after each resume
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      guard_ff <= '0;
    else if (done && cmd_ff == CMD_RESUME)
      guard_ff <= RW'(RESUME_CYC);
    else if (guard_ff != '0)
      guard_ff <= guard_ff - 1'b1;
  end

  assign guard_end = guard_ff == RW'(1);

  // ==========================================================================
  // Interrupts: set wins over a clear in the same cycle
  always_comb
  begin
    irq_set            = '0;
    irq_set[IRQ_DONE]  = done;
    irq_set[IRQ_GUARD] = guard_end;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      irq_stat_ff <= '0;
    else if (reg_wr && reg_addr == REG_IRQ_CLR)
      irq_stat_ff <= (irq_stat_ff & ~reg_wdata[IRQ_W-1:0]) | irq_set;
    else
      irq_stat_ff <= irq_stat_ff | irq_set;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      irq_en_ff <= '0;
    else if (reg_wr && reg_addr == REG_IRQ_EN)
      irq_en_ff <= reg_wdata[IRQ_W-1:0];
  end

  assign irq = |(irq_stat_ff & irq_en_ff);

  // ==========================================================================
  // Register read
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      reg_rdata <= '0;
      unique case (reg_addr)
        REG_WPCTL:    reg_rdata[0] <= ~link.wp_n;
        REG_STATUS:
        begin
          reg_rdata[STR_BUSY]               <= st_ff != H_IDLE;
          reg_rdata[STR_GUARD]              <= guard_ff != '0;
          reg_rdata[STR_BYTE_LSB +: 8]      <= stat_byte_ff;
        end
        REG_IRQ_STAT: reg_rdata[IRQ_W-1:0] <= irq_stat_ff;
        REG_IRQ_EN:   reg_rdata[IRQ_W-1:0] <= irq_en_ff;
        default:      ;
      endcase
    end
  end

endmodule // fspr_host

// file: tb/fspr_asserts.sv
`timescale 1ns/1ps
module fspr_asserts (
  // Clock and reset
  input logic       clk_sys,
  input logic       sys_rst,
  // Link
  input logic       sck,
  input logic       cs_n,
  input logic       wp_n,
  input logic       miso_oe,
  // Device state
  input logic       busy,
  input logic       resuming,
  input logic       resume_prog,
  input logic       resume_erase,
  input logic       susp_req,
  input logic       prog_suspend_flag_a,
  input logic       prog_suspend_flag_b,
  input logic       erase_suspend_flag,
  input logic       prot_en,
  input logic       chk_valid,
  input logic       chk_table,
  input logic [7:0] chk_tbl_byte,
  input logic       chk_done,
  input logic       chk_deny
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ========
  // Framing
  chk_sck_idle: assert property (cs_n |-> !sck)
    else $error("serial clock moved outside a frame");
  chk_miso_free: assert property (cs_n [*8] |-> !miso_oe)
    else $error("data line driven while deselected");
  // ========
  // Resume
  chk_resume_busy: assert property ((resume_prog || resume_erase) |-> ##[0:1] (busy && resuming))
    else $error("resumed work not reported busy");
  chk_erase_flag: assert property (resume_erase |-> ##[0:1] !erase_suspend_flag)
    else $error("erase flag kept after resume");
  chk_prog_first: assert property (resume_erase |-> !(prog_suspend_flag_a || prog_suspend_flag_b))
    else $error("erase resumed ahead of program");
  chk_susp_ignored: assert property ((resuming && susp_req)
    |=> $stable({prog_suspend_flag_a, prog_suspend_flag_b, erase_suspend_flag}))
    else $error("suspend taken while resuming");
  // ========
  // Protection
  chk_wp_enables: assert property (!wp_n [*8] |-> prot_en)
    else $error("held pin did not protect");
  // Two-cycle dip, shorter than the filter, as the bench makes it
  chk_wp_glitch: assert property ((!prot_en ##1 $fell(wp_n) ##1 !wp_n ##1 wp_n) |-> !prot_en [*6])
    else $error("pin glitch changed protection");
  chk_unmarked_open: assert property ((chk_valid && !chk_table && chk_tbl_byte != 8'hff)
    |=> chk_done && !chk_deny)
    else $error("unmarked sector refused");
  chk_marked_deny: assert property ((chk_valid && !chk_table && chk_tbl_byte == 8'hff && prot_en)
    |=> chk_done && chk_deny)
    else $error("marked sector not refused");
  chk_table_deny: assert property ((!wp_n [*8] ##0 (chk_valid && chk_table)) |=> chk_deny)
    else $error("table writable under pin");
endmodule // fspr_asserts

// file: tb/flash_sector_protect_resume_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module flash_sector_protect_resume_tb
  import fspr_pkg::*;
;
  localparam int RES_CYC = 20;
  logic        clk_sys, sys_rst, reg_wr, reg_rd, irq;
  logic [7:0]  reg_addr, chk_tbl_byte;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic        op_start, op_done, susp_req, chk_valid, chk_table;
  logic [1:0]  susp_kind;
  logic        resume_prog, resume_erase, busy, resuming, chk_done, chk_deny, prot_en;
  logic        prog_suspend_flag_a, prog_suspend_flag_b, erase_suspend_flag;
  int          mismatches, n_tests;

  fspr_link_if link ();
  fspr_host #(.RESUME_CYC(RES_CYC)) fspr_host_i (.clk_sys, .sys_rst, .link, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq);
  fspr_device #(.RESUME_CYC(RES_CYC), .WP_FILT_CYC(3)) fspr_device_i (.clk_sys, .sys_rst, .link,
    .op_start, .op_done, .susp_req, .susp_kind, .resume_prog, .resume_erase, .busy, .resuming,
    .prog_suspend_flag_a, .prog_suspend_flag_b, .erase_suspend_flag, .prot_en, .chk_valid,
    .chk_table, .chk_tbl_byte, .chk_done, .chk_deny);
  fspr_asserts fspr_asserts_i (.clk_sys, .sys_rst, .sck(link.sck), .cs_n(link.cs_n),
    .wp_n(link.wp_n), .miso_oe(link.miso_oe), .busy, .resuming, .resume_prog, .resume_erase,
    .susp_req, .prog_suspend_flag_a, .prog_suspend_flag_b, .erase_suspend_flag, .prot_en,
    .chk_valid, .chk_table, .chk_tbl_byte, .chk_done, .chk_deny);

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ========
  // Bus and engine helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Device acts a few cycles after select rise, well before the irq
  task automatic wirq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (irq !== 1'b1)
      mismatches++;
    wr(REG_IRQ_CLR, 32'h3);
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task automatic cmd(input logic [1:0] c);
    wr(REG_CTRL, {30'h0, c});
    wirq();
  endtask

  task automatic eng(input int s, input logic [1:0] k);
    @(posedge clk_sys);
    op_start  <= (s == 0);
    op_done   <= (s == 1);
    susp_req  <= (s == 2);
    susp_kind <= k;
    @(posedge clk_sys);
    op_start <= 1'b0;
    op_done  <= 1'b0;
    susp_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic acc(input logic t, input logic [7:0] b, input logic e);
    @(posedge clk_sys);
    chk_valid    <= 1'b1;
    chk_table    <= t;
    chk_tbl_byte <= b;
    @(posedge clk_sys);
    chk_valid <= 1'b0;
    #1;
    `CHK(chk_done, 1'b1)
    `CHK(chk_deny, e)
  endtask

  task automatic wp(input logic v, input int n);
    wr(REG_WPCTL, {31'h0, v});
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // ========
  // Scenarios
  task automatic t_reset();
    `CHK({prot_en, busy, erase_suspend_flag, prog_suspend_flag_a}, 4'h0)
    rd(8'h20);
    `CHK(d, 32'h0)
    wr(REG_IRQ_EN, 32'h1);
    rd(REG_IRQ_EN);
    `CHK(d[1:0], 2'h1)
  endtask

  task automatic t_soft();
    cmd(CMD_ENABLE);
    `CHK(prot_en, 1'b1)
    acc(1'b0, 8'hff, 1'b1);
    acc(1'b0, 8'h00, 1'b0);
    acc(1'b1, 8'hff, 1'b0);
    cmd(CMD_STATUS);
    rd(REG_STATUS);
    `CHK(d[STR_BYTE_LSB+ST_PROT], 1'b1)
    cmd(CMD_DISABLE);
    `CHK(prot_en, 1'b0)
  endtask

  task automatic t_wp();
    wp(1'b1, 0);
    wp(1'b0, 10);
    `CHK(prot_en, 1'b0)
    wp(1'b1, 12);
    `CHK(prot_en, 1'b1)
    acc(1'b1, 8'h00, 1'b1);
    cmd(CMD_DISABLE);
    `CHK(prot_en, 1'b1)
    wp(1'b0, 12);
    `CHK(prot_en, 1'b0)
    wp(1'b1, 12);
    cmd(CMD_ENABLE);
    wp(1'b0, 12);
    `CHK(prot_en, 1'b1)
    cmd(CMD_DISABLE);
    `CHK(prot_en, 1'b0)
  endtask

  task automatic t_resume();
    int n;
    eng(0, SUSP_PROG_A);
    eng(2, SUSP_ERASE);
    eng(0, SUSP_PROG_A);
    eng(2, SUSP_PROG_A);
    `CHK({erase_suspend_flag, prog_suspend_flag_a}, 2'b11)
    cmd(CMD_STATUS);
    rd(REG_STATUS);
    `CHK(d[15:12], 4'he)
    wr(REG_CTRL, {30'h0, CMD_RESUME});
    n = 0;
    while (busy !== 1'b1 && n < 1000)
    begin
      @(posedge clk_sys);
      n++;
    end
    // Suspend arrives while the device is still resuming, before the guard starts, and is ignored
    eng(2, SUSP_PROG_A);
    `CHK({busy, prog_suspend_flag_a, erase_suspend_flag}, 3'b101)
    wirq();
    repeat (RES_CYC + 10) @(posedge clk_sys);
    rd(REG_IRQ_STAT);
    `CHK({irq, d[1:0]}, 3'b010)
    wr(REG_IRQ_CLR, 32'h3);
    eng(1, SUSP_PROG_A);
    cmd(CMD_RESUME);
    `CHK({busy, erase_suspend_flag}, 2'b10)
    eng(1, SUSP_PROG_A);
    // Host keeps the full resume time before a new suspend
    repeat (RES_CYC) @(posedge clk_sys);
    eng(0, SUSP_PROG_B);
    eng(2, SUSP_PROG_B);
    `CHK({busy, prog_suspend_flag_b}, 2'b01)
    cmd(CMD_RESUME);
    `CHK({busy, prog_suspend_flag_b}, 2'b10)
    eng(1, SUSP_PROG_B);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    {sys_rst, reg_wr, reg_rd, op_start, op_done, susp_req, chk_valid, chk_table} = 8'h80;
    {reg_addr, chk_tbl_byte, susp_kind, reg_wdata} = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_soft();
    t_wp();
    t_resume();
    print_verdict();
  end

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    print_verdict();
  end
endmodule // flash_sector_protect_resume_tb
